/* ssio_pkg.sv */
package ssio_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_GPIO0_CONFIG = 8'h0D;
	localparam logic [7:0] IDX_GPIO1_GPIO2_CONFIG = 8'h0E;
	localparam logic [7:0] IDX_GPIO3_OUT4_CONFIG = 8'h0F;
	localparam logic [7:0] IDX_OUT5_OUT6_CONTROL = 8'h10;
	localparam logic [7:0] IDX_OUT7_OUT8_CONTROL = 8'h11;
	localparam logic [7:0] IDX_DATA_PATH_CONFIG = 8'h12;
	localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'hC6;
	localparam logic [7:0] IDX_INTERRUPT_STATUS = 8'hC7;
	localparam logic [7:0] IDX_PATTERN_CONTROL = 8'h64;
	localparam logic [7:0] IDX_SIDEBAND_STATUS = 8'h65;

	// reset values
	localparam logic [7:0] RST_REG = 8'h00;

	// field positions
	localparam int INTCTL_GLOBAL_EN_BIT = 0;
	localparam int INTCTL_REMOTE_EN_BIT = 5;
	localparam int DPC_SECONDARY_AUDIO_BIT = 0;
	localparam int DPC_MODE18_BIT = 2;
	localparam int PAT_ENABLE_BIT = 0;
	localparam int PAT_FORCE_OSC_BIT = 1;
	localparam int PAT_AUDIO_ACTIVE_BIT = 2;
	localparam int PAT_DIV_LSB = 4;
	localparam int ISR_PENDING_BIT = 0;
	localparam int ISR_REMOTE_LEVEL_BIT = 1;

	// nibble codes: enable bit 0, direction in bits 2:1, level in bit 3
	localparam logic [1:0] GPIO_DIR_FORWARD = 2'h1;
	localparam logic [1:0] GPIO_DIR_BACK = 2'h2;
	localparam int GPO_LEVEL_BIT = 3;

	// audio word length limit in bits
	localparam int AUDIO_MAX_BITS = 32;

	// one received audio word pair
	typedef struct packed {
		logic [31:0] primary;
		logic [31:0] secondary;
		logic word_select;
		logic [5:0] bit_count;
	} ssio_audio_type;
endpackage : ssio_pkg

/* ssio_sideband.sv */
`timescale 1ns/100ps
`default_nettype none
module ssio_sideband #(
	parameter int ADDR_W = 12
) (
	// clock, reset, enable
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	input wire logic remote_interrupt_in_n,
	output logic interrupt_out_n,
	// colour-bit gpios and link gpio data
	input wire logic [3:0] gpio_pin_in,
	output logic [3:0] gpio_pin_out,
	output logic [3:0] gpio_pin_oe,
	input wire logic [3:0] gpio_back_channel,
	output logic [3:0] gpio_forward_channel,
	output logic [3:0] gpio_forward_valid,
	// register-driven outputs 8 to 4
	output logic [4:0] register_driven_output,
	// mode pins and status
	input wire logic power_down_n,
	input wire logic mode_sel_secondary,
	input wire logic backward_compat,
	input wire logic pixel_clock_present,
	input wire logic bist_request,
	output logic bist_active,
	output logic mode_18bit,
	// test pattern
	output logic pattern_active,
	output logic pattern_on_osc,
	output logic pattern_pixel_valid,
	output logic [23:0] pattern_pixel,
	// audio
	input wire logic audio_bit_clock,
	input wire logic audio_word_select,
	input wire logic primary_audio_data,
	input wire logic secondary_audio_data,
	input wire logic video_blanking,
	output logic audio_valid,
	output ssio_pkg::ssio_audio_type audio_word,
	output logic audio_secondary_en
);
	// gpio nibble decode
	function automatic logic [1:0] gpio_mode(input logic [3:0] nib);
		gpio_mode = nib[0] ? nib[2:1] : 2'h0;
	endfunction : gpio_mode

	// output nibble decode: enabled level
	function automatic logic gpo_level(input logic [3:0] nib);
		gpo_level = nib[0] & nib[ssio_pkg::GPO_LEVEL_BIT];
	endfunction : gpo_level

	// registers
	logic [7:0] gpio0_cfg_r, gpio12_cfg_r, gpio3_out4_r, out56_r, out78_r;
	logic [7:0] dpc_r, intctl_r, patctl_r;
	logic pending_r;
	logic pready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	// two-flop synchronisers for every pin input except video_blanking
	localparam int SYN_W = 18;
	logic [SYN_W-1:0] syn1_r, syn2_r;
	// remote line clears to its idle high, else reset would look like a falling edge
	localparam logic [SYN_W-1:0] SYN_IDLE = {1'h1, {(SYN_W-1){1'h0}}};
	logic [SYN_W-1:0] pins;
	assign pins = {remote_interrupt_in_n, gpio_pin_in, gpio_back_channel, power_down_n,
		mode_sel_secondary, backward_compat, pixel_clock_present, bist_request,
		audio_bit_clock, audio_word_select, primary_audio_data, secondary_audio_data};
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			syn1_r <= SYN_IDLE;
			syn2_r <= SYN_IDLE;
		end else if (clk_en) begin
			syn1_r <= pins;
			syn2_r <= syn1_r;
		end
	end

	// named synchronised levels
	wire logic rint_s = syn2_r[17];
	wire logic [3:0] gpin_s = syn2_r[16:13];
	wire logic [3:0] gback_s = syn2_r[12:9];
	wire logic pdn_s = syn2_r[8];
	wire logic msel_s = syn2_r[7];
	wire logic bcomp_s = syn2_r[6];
	wire logic pclk_s = syn2_r[5];
	wire logic bist_s = syn2_r[4];
	wire logic bclk_s = syn2_r[3];
	wire logic ws_s = syn2_r[2];
	wire logic da_s = syn2_r[1];
	wire logic db_s = syn2_r[0];

	// apb decode
	wire logic [7:0] idx = paddr[9:2];
	wire logic upper_zero = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0);
	wire logic access = psel && penable && pready_r;
	wire logic wr_go = access && pwrite;
	wire logic rd_go = access && !pwrite;
	wire logic hit_g0 = upper_zero && idx == ssio_pkg::IDX_GPIO0_CONFIG;
	wire logic hit_g12 = upper_zero && idx == ssio_pkg::IDX_GPIO1_GPIO2_CONFIG;
	wire logic hit_g3 = upper_zero && idx == ssio_pkg::IDX_GPIO3_OUT4_CONFIG;
	wire logic hit_o56 = upper_zero && idx == ssio_pkg::IDX_OUT5_OUT6_CONTROL;
	wire logic hit_o78 = upper_zero && idx == ssio_pkg::IDX_OUT7_OUT8_CONTROL;
	wire logic hit_dpc = upper_zero && idx == ssio_pkg::IDX_DATA_PATH_CONFIG;
	wire logic hit_ic = upper_zero && idx == ssio_pkg::IDX_INTERRUPT_CONTROL;
	wire logic hit_isr = upper_zero && idx == ssio_pkg::IDX_INTERRUPT_STATUS;
	wire logic hit_pat = upper_zero && idx == ssio_pkg::IDX_PATTERN_CONTROL;
	wire logic hit_st = upper_zero && idx == ssio_pkg::IDX_SIDEBAND_STATUS;
	wire logic hit_any = hit_g0 | hit_g12 | hit_g3 | hit_o56 | hit_o78 | hit_dpc | hit_ic
		| hit_isr | hit_pat | hit_st;

	// derived modes
	wire logic mode18 = dpc_r[ssio_pkg::DPC_MODE18_BIT];
	wire logic sec_en = msel_s | dpc_r[ssio_pkg::DPC_SECONDARY_AUDIO_BIT];
	wire logic [15:0] gpio_nibs = {gpio3_out4_r[3:0], gpio12_cfg_r[7:4], gpio12_cfg_r[3:0],
		gpio0_cfg_r[3:0]};

	// status words
	wire logic [7:0] isr_word = {6'h00, rint_s, pending_r};
	wire logic [7:0] st_word = {bist_active, pattern_active, sec_en, mode18, gpin_s};

	// read mux
	wire logic [7:0] rd_byte =
		hit_g0 ? gpio0_cfg_r :
		hit_g12 ? gpio12_cfg_r :
		hit_g3 ? gpio3_out4_r :
		hit_o56 ? out56_r :
		hit_o78 ? out78_r :
		hit_dpc ? dpc_r :
		hit_ic ? intctl_r :
		hit_isr ? isr_word :
		hit_pat ? patctl_r :
		hit_st ? st_word : 8'h00;

	// apb handshake: one wait state on every access
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (clk_en) begin
			pready_r <= psel && penable && !pready_r;
			prdata_r <= (psel && penable && !pready_r && !pwrite) ? {24'h00_0000, rd_byte}
				: 32'h0000_0000;
			pslverr_r <= psel && penable && !pready_r && !hit_any;
		end
	end

	// writable registers; narrow data in the low byte
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gpio0_cfg_r <= ssio_pkg::RST_REG;
			gpio12_cfg_r <= ssio_pkg::RST_REG;
			gpio3_out4_r <= ssio_pkg::RST_REG;
			out56_r <= ssio_pkg::RST_REG;
			out78_r <= ssio_pkg::RST_REG;
			dpc_r <= ssio_pkg::RST_REG;
			intctl_r <= ssio_pkg::RST_REG;
			patctl_r <= ssio_pkg::RST_REG;
		end else if (clk_en && wr_go) begin
			if (hit_g0) gpio0_cfg_r <= pwdata[7:0];
			if (hit_g12) gpio12_cfg_r <= pwdata[7:0];
			if (hit_g3) gpio3_out4_r <= pwdata[7:0];
			if (hit_o56) out56_r <= pwdata[7:0];
			if (hit_o78) out78_r <= pwdata[7:0];
			if (hit_dpc) dpc_r <= pwdata[7:0];
			if (hit_ic) intctl_r <= pwdata[7:0];
			if (hit_pat) patctl_r <= pwdata[7:0];
		end
	end

	// interrupt: falling edge of synced remote line sets pending
	logic rint_d_r;
	wire logic int_en = intctl_r[ssio_pkg::INTCTL_REMOTE_EN_BIT]
		& intctl_r[ssio_pkg::INTCTL_GLOBAL_EN_BIT];
	wire logic rint_fall = rint_d_r && !rint_s;
	wire logic isr_read = rd_go && hit_isr;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rint_d_r <= 1'b1;
			pending_r <= 1'b0;
			interrupt_out_n <= 1'b1;
		end else if (clk_en) begin
			rint_d_r <= rint_s;
			// a new edge in the clearing cycle wins over the read
			pending_r <= (int_en && rint_fall) || (pending_r && !isr_read);
			interrupt_out_n <= !((int_en && rint_fall) || (pending_r && !isr_read));
		end
	end

	// gpio direction per bit; only meaningful in 18-bit mode
	logic [3:0] g_fwd, g_back;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_gpio
			assign g_fwd[gi] = mode18 && gpio_mode(gpio_nibs[gi*4 +: 4])
				== ssio_pkg::GPIO_DIR_FORWARD;
			assign g_back[gi] = mode18 && gpio_mode(gpio_nibs[gi*4 +: 4])
				== ssio_pkg::GPIO_DIR_BACK;
		end
	endgenerate

	// output nibbles: out4..out8
	wire logic [4:0] gpo_next = {gpo_level(out78_r[7:4]), gpo_level(out78_r[3:0]),
		gpo_level(out56_r[7:4]), gpo_level(out56_r[3:0]), gpo_level(gpio3_out4_r[7:4])};

	// pin-facing gpio and register-driven outputs
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gpio_pin_out <= 4'h0;
			gpio_pin_oe <= 4'h0;
			gpio_forward_channel <= 4'h0;
			gpio_forward_valid <= 4'h0;
			register_driven_output <= 5'h00;
			mode_18bit <= 1'b0;
			audio_secondary_en <= 1'b0;
			bist_active <= 1'b0;
		end else if (clk_en) begin
			gpio_pin_out <= gback_s & g_back;
			gpio_pin_oe <= g_back;
			gpio_forward_channel <= gpin_s & g_fwd;
			gpio_forward_valid <= g_fwd;
			register_driven_output <= gpo_next;
			mode_18bit <= mode18;
			audio_secondary_en <= sec_en && !mode18;
			bist_active <= bist_s && !bcomp_s && pdn_s;
		end
	end

	// test pattern: colour bars, stepped by pixel clock or divider
	logic [3:0] osc_cnt_r;
	logic [10:0] pat_cnt_r;
	wire logic pat_en = patctl_r[ssio_pkg::PAT_ENABLE_BIT] && pdn_s;
	wire logic use_osc = !pclk_s || patctl_r[ssio_pkg::PAT_FORCE_OSC_BIT];
	wire logic [3:0] osc_div = patctl_r[ssio_pkg::PAT_DIV_LSB +: 4];
	wire logic osc_tick = osc_cnt_r == osc_div;
	wire logic pat_step = pat_en && (!use_osc || osc_tick);
	wire logic [2:0] bar = pat_cnt_r[10:8];
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			osc_cnt_r <= 4'h0;
			pat_cnt_r <= 11'h000;
			pattern_active <= 1'b0;
			pattern_on_osc <= 1'b0;
			pattern_pixel_valid <= 1'b0;
			pattern_pixel <= 24'h00_0000;
		end else if (clk_en) begin
			osc_cnt_r <= (osc_tick || !pat_en) ? 4'h0 : osc_cnt_r + 4'h1;
			if (pat_step) pat_cnt_r <= pat_cnt_r + 11'h001;
			pattern_active <= pat_en;
			pattern_on_osc <= pat_en && use_osc;
			pattern_pixel_valid <= pat_step;
			pattern_pixel <= {{8{bar[2]}}, {8{bar[1]}}, {8{bar[0]}}};
		end
	end

	// audio receiver: 24-bit mode only; pin rate at most a quarter of clock
	logic bclk_d_r;
	logic ws_d_r;
	logic [31:0] sh_a_r, sh_b_r;
	logic [5:0] bits_r;
	wire logic audio_on = !mode18 && pdn_s;
	wire logic bclk_rise = bclk_s && !bclk_d_r;
	wire logic ws_change = bclk_rise && (ws_s != ws_d_r);
	wire logic in_active = patctl_r[ssio_pkg::PAT_AUDIO_ACTIVE_BIT];
	wire logic slot_ok = in_active || video_blanking;
	wire logic [5:0] bits_inc = (bits_r == 6'(ssio_pkg::AUDIO_MAX_BITS)) ? bits_r
		: bits_r + 6'h01;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bclk_d_r <= 1'b0;
			ws_d_r <= 1'b0;
			sh_a_r <= 32'h0000_0000;
			sh_b_r <= 32'h0000_0000;
			bits_r <= 6'h00;
		end else if (clk_en) begin
			bclk_d_r <= bclk_s;
			if (bclk_rise && audio_on) begin
				ws_d_r <= ws_s;
				sh_a_r <= {sh_a_r[30:0], da_s};
				sh_b_r <= {sh_b_r[30:0], db_s & sec_en};
				bits_r <= ws_change ? 6'h01 : bits_inc;
			end
		end
	end

	// finished word is handed over when word select flips
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			audio_valid <= 1'b0;
			audio_word <= '0;
		end else if (clk_en) begin
			audio_valid <= ws_change && audio_on && slot_ok && bits_r != 6'h00;
			if (ws_change && audio_on) begin
				audio_word.primary <= sh_a_r;
				audio_word.secondary <= sec_en ? sh_b_r : 32'h0000_0000;
				audio_word.word_select <= ws_d_r;
				audio_word.bit_count <= bits_r;
			end
		end
	end

	// bus outputs
	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
endmodule : ssio_sideband
`default_nettype wire

/* ssio_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
module ssio_far_end (
	// clock and bench commands
	input wire logic clock,
	input wire logic raise,
	input wire logic [3:0] back_level,
	// lines toward the serializer
	output logic remote_interrupt_in_n = 1'h1,
	output logic [3:0] gpio_back_channel = 4'h0
);
	// pulled-up line: low only while raise is held, released one clock after raise drops
	always @(posedge clock) begin
		remote_interrupt_in_n <= !raise;
		gpio_back_channel <= back_level;
	end
endmodule : ssio_far_end
`default_nettype wire

/* ssio_sideband_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module ssio_sideband_sva #(
	parameter int ADDR_W = 12
) (
	// clock, reset
	input wire logic clock,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// sideband
	input wire logic remote_interrupt_in_n,
	input wire logic interrupt_out_n,
	input wire logic [4:0] register_driven_output,
	input wire logic power_down_n,
	input wire logic backward_compat,
	input wire logic bist_active,
	input wire logic mode_18bit,
	input wire logic pattern_active
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// completed transfers by word index
	wire [7:0] idx = paddr[9:2];
	wire wr = psel && penable && pready && pwrite;
	wire isr_rd = psel && penable && pready && !pwrite && idx == ssio_pkg::IDX_INTERRUPT_STATUS;
	logic en_r;
	// both enables as last written; one alone is not enough
	always_ff @(posedge clock)
		if (!rst_n)
			en_r <= 1'h0;
		else if (wr && idx == ssio_pkg::IDX_INTERRUPT_CONTROL)
			en_r <= pwdata[5] && pwdata[0];
	a_int_raise: assert property (en_r && $fell(remote_interrupt_in_n)
		|-> ##4 !interrupt_out_n) else $error("interrupt not raised");
	a_int_gated: assert property (!en_r [*2] ##0 interrupt_out_n
		|=> interrupt_out_n) else $error("interrupt while disabled");
	a_int_refall: assert property (!remote_interrupt_in_n [*6] ##0 interrupt_out_n
		|=> interrupt_out_n) else $error("interrupt without new fall");
	a_int_clear: assert property (remote_interrupt_in_n [*6] ##0 isr_rd
		|=> ##1 interrupt_out_n) else $error("status read did not release");
	a_gpo_level: assert property (wr && idx == 8'h11 && pwdata[4] && pwdata[0]
		|=> ##1 register_driven_output[4:3] == $past({pwdata[7], pwdata[3]}, 2))
		else $error("output level wrong");
	a_gpo_hold: assert property (!$stable(register_driven_output)
		|-> $past(wr) || $past(wr, 2)) else $error("output moved without write");
	a_mode_set: assert property (wr && idx == 8'h12 && pwdata[7:0] == 8'h04
		|=> ##1 mode_18bit) else $error("18-bit mode not set");
	a_bist_compat: assert property (backward_compat [*4] |-> !bist_active)
		else $error("self test in compatible mode");
	a_pattern_off: assert property (!power_down_n [*4] |-> !pattern_active)
		else $error("pattern while powered down");
endmodule : ssio_sideband_sva
bind ssio_sideband ssio_sideband_sva #(.ADDR_W(ADDR_W)) ssio_sideband_sva_i (.clock, .rst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .remote_interrupt_in_n,
	.interrupt_out_n, .register_driven_output, .power_down_n, .backward_compat, .bist_active,
	.mode_18bit, .pattern_active);
`default_nettype wire

/* serializer_sideband_io_test.sv */
`timescale 1ns/100ps
`default_nettype none
module serializer_sideband_io_test;
	// bench drives
	logic clock = 1'h0, rst_n = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic power_down_n = 1'h1, mode_sel_secondary = 1'h0, backward_compat = 1'h0, raise = 1'h0;
	logic pixel_clock_present = 1'h1, bist_request = 1'h0, audio_bit_clock = 1'h0;
	logic audio_word_select = 1'h0, primary_audio_data = 1'h0, secondary_audio_data = 1'h0;
	logic video_blanking = 1'h0, err;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rdata, prdata, lfsr = 32'h0597CDB9;
	logic [3:0] gpio_pin_in = 4'h0, back_level = 4'h0;
	logic [7:0] idxs [7] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'hC6};
	// design and far-end outputs
	logic pready, pslverr, remote_interrupt_in_n, interrupt_out_n, bist_active, mode_18bit;
	logic pattern_active, pattern_on_osc, pattern_pixel_valid, audio_valid, audio_secondary_en;
	logic [3:0] gpio_pin_out, gpio_pin_oe, gpio_back_channel, gpio_forward_channel;
	logic [3:0] gpio_forward_valid;
	logic [4:0] register_driven_output;
	logic [23:0] pattern_pixel;
	ssio_pkg::ssio_audio_type audio_word, got[$];
	int n_errors = 0, n_compared = 0, n_steps = 0;
	ssio_sideband #(.ADDR_W(12)) ssio_sideband_i (.clock, .rst_n, .clk_en, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .remote_interrupt_in_n,
		.interrupt_out_n, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe, .gpio_back_channel,
		.gpio_forward_channel, .gpio_forward_valid, .register_driven_output, .power_down_n,
		.mode_sel_secondary, .backward_compat, .pixel_clock_present, .bist_request,
		.bist_active, .mode_18bit, .pattern_active, .pattern_on_osc, .pattern_pixel_valid,
		.pattern_pixel, .audio_bit_clock, .audio_word_select, .primary_audio_data,
		.secondary_audio_data, .video_blanking, .audio_valid, .audio_word, .audio_secondary_en);
	ssio_far_end ssio_far_end_i (.clock, .raise, .back_level, .remote_interrupt_in_n,
		.gpio_back_channel);
	// 40 MHz clock
	always #12.5 clock = !clock;
	// finished audio words, taken in their one valid cycle
	always @(posedge clock)
		if (audio_valid === 1'h1)
			got.push_back(audio_word);
	// pattern steps, counted by non-blocking update so reads see a settled count
	always @(posedge clock)
		if (pattern_pixel_valid === 1'h1)
			n_steps <= n_steps + 1;
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [70:0] seen, input logic [70:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer; request held until pready, then an idle edge
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rdata = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			n_errors++;
			wrap_up();
		end
		@(posedge clock);
	endtask : apb
	// msb first, one bit per four clocks
	task automatic send(input logic ws, input logic [31:0] a, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			audio_word_select <= ws;
			primary_audio_data <= a[i];
			secondary_audio_data <= !a[i];
			audio_bit_clock <= 1'h0;
			tick(2);
			audio_bit_clock <= 1'h1;
			tick(2);
		end
	endtask : send
	initial begin
		logic [31:0] d;
		tick(10);
		rst_n <= 1'h1;
		foreach (idxs[i]) begin
			apb(1'h0, idxs[i], 8'h0);
			chk(rdata, 0);
		end
		apb(1'h0, 8'h01, 8'h0);
		chk({err, rdata}, 33'h100000000);
		// fixed codes first, then random levels, every output nibble enabled
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'h90 : (i == 1) ? 8'h10 : lfsr[7:0];
			d = d | 8'h11;
			lfsr = lfsr_next(lfsr);
			apb(1'h1, 8'h11, d[7:0]);
			apb(1'h1, 8'h10, {d[3:0], d[7:4]});
			apb(1'h1, 8'h0F, {d[7:4], 4'h0});
			apb(1'h0, 8'h11, 8'h0);
			chk(rdata, d[7:0]);
			chk(register_driven_output, {d[7], d[3], d[3], d[7], d[7]});
		end
		raise <= 1'h1;
		tick(8);
		chk(interrupt_out_n, 1);
		raise <= 1'h0;
		tick(4);
		apb(1'h1, 8'hC6, 8'h21);
		for (int n = 0; n < 2; n++) begin
			raise <= 1'h1;
			tick(6);
			chk(interrupt_out_n, 0);
			if (n == 1) begin
				raise <= 1'h0;
				tick(8);
			end
			apb(1'h0, 8'hC7, 8'h0);
			chk(rdata[0], 1);
			tick(1);
			chk(interrupt_out_n, 1);
			tick(10);
			chk(interrupt_out_n, 1);
			raise <= 1'h0;
			tick(4);
		end
		apb(1'h1, 8'h12, 8'h04);
		apb(1'h1, 8'h0F, 8'h05);
		apb(1'h1, 8'h0D, 8'h93);
		apb(1'h1, 8'h0E, 8'h53);
		back_level <= lfsr[3:0];
		gpio_pin_in <= lfsr[7:4];
		tick(6);
		chk(mode_18bit, 1);
		chk({gpio_pin_oe[3], gpio_pin_out[3], gpio_forward_valid[0]}, {1'h1, lfsr[3], 1'h1});
		chk(gpio_forward_channel[0], lfsr[4]);
		chk({gpio_pin_oe, gpio_forward_valid, gpio_pin_out, gpio_forward_channel},
			{8'hC3, lfsr[3:2], 2'h0, 2'h0, lfsr[5:4]});
		apb(1'h1, 8'h64, 8'h01);
		pixel_clock_present <= 1'h0;
		bist_request <= 1'h1;
		// long enough for the pattern counter to reach the second bar
		tick(300);
		chk({pattern_active, pattern_on_osc, bist_active}, 3'h7);
		// divider 3: one step every four clocks
		apb(1'h1, 8'h64, 8'h31);
		d = n_steps;
		tick(40);
		chk(n_steps - d, 10);
		power_down_n <= 1'h0;
		backward_compat <= 1'h1;
		tick(6);
		chk({pattern_active, bist_active}, 2'h0);
		chk(pattern_pixel, {{8{n_steps[10]}}, {8{n_steps[9]}}, {8{n_steps[8]}}});
		power_down_n <= 1'h1;
		apb(1'h1, 8'h12, 8'h00);
		mode_sel_secondary <= 1'h1;
		video_blanking <= 1'h1;
		tick(4);
		chk(audio_secondary_en, 1);
		d = lfsr_next(lfsr);
		send(1'h0, d, 32);
		send(1'h1, lfsr, 16);
		send(1'h0, 32'h0, 1);
		tick(4);
		chk(got[0], {d, ~d, 1'h0, 6'h20});
		chk({got[1].primary[15:0], got[1].bit_count, got[1].word_select}, {lfsr[15:0], 7'h21});
		// blanking low and active-video slot off: word dropped, then allowed
		video_blanking <= 1'h0;
		send(1'h1, d, 2);
		tick(4);
		chk(got.size(), 2);
		apb(1'h1, 8'h64, 8'h04);
		send(1'h0, d, 2);
		tick(4);
		chk(got.size(), 3);
		chk({got[2].primary[1:0], got[2].bit_count, got[2].word_select}, {d[1:0], 7'h05});
		apb(1'h1, 8'h12, 8'h04);
		send(1'h0, d, 4);
		send(1'h1, d, 1);
		tick(4);
		chk(got.size(), 3);
		// frozen clock enable: a pin change waits until it returns
		clk_en <= 1'h0;
		gpio_pin_in <= ~lfsr[7:4];
		tick(6);
		chk(gpio_forward_channel, {2'h0, lfsr[5:4]});
		clk_en <= 1'h1;
		tick(6);
		chk(gpio_forward_channel, {2'h0, ~lfsr[5:4]});
		wrap_up();
	end
endmodule : serializer_sideband_io_test
`default_nettype wire
